// File: core/gesc_regs.vh
`ifndef GESC_REGS_VH
`define GESC_REGS_VH
// Contract
// - Servo mode swaps in servo cutoff, boost
// - Cutoff and boost held as 7-bit codes
// - Adapt enable gates coefficient, else frozen
// - Second bit adds user data adaptation
// - One coefficient, driven to null zeros
// - Synth rate follows (M+1)/(N+1) registers
// - M and N commit on rate write
// - Synth to test pins in write/idle
// - Decision-directed detector only in read
// - Threshold 1.27x before sync count
// - Fixed or adaptive thresholds after count
// - Three-bit time constant sets adapt rate
// - Damping is 7-bit field, rate independent
// - Write chain on synth clock, toggle out; code clocks it on CLK_SYS
// - Code keeps at most four zeros; code allows eight across a word boundary
// - Byte encoded to 9 bits, serialised
// - Find word boundary, deserialise, decode
// - Control bit 2 enables scrambling
// - Only bytes after sync byte scrambled
// - Polynomial 1 xor X7 xor X10
// - Read order detect, sync, decode, descramble
// - Write order mark, preamble, data
// - Sync byte 96H, first nonzero byte
// - Servo over read over write
`define GESC_A_CTRL 8'h00
`define GESC_A_DFC 8'h04
`define GESC_A_DBOOST 8'h08
`define GESC_A_SFC 8'h0C
`define GESC_A_SBOOST 8'h10
`define GESC_A_SLOOP 8'h14
`define GESC_A_THRESH 8'h18
`define GESC_A_WPLT 8'h1C
`define GESC_A_DAMP 8'h20
`define GESC_A_SYN_M 8'h24
`define GESC_A_SYN_N 8'h28
`define GESC_A_RATE 8'h2C
`define GESC_A_TEST 8'h30
`define GESC_A_STATUS 8'h34
`define GESC_A_SYNCCNT 8'h38
`define GESC_CTRL_SCR_BIT 2
`define GESC_SL_ON_BIT 0
`define GESC_SL_USER_BIT 1
`define GESC_WL_ADAPT_BIT 0
`define GESC_WL_TC_HI 3
`define GESC_WL_TC_LO 1
`define GESC_TEST_SYN_BIT 0
`define GESC_CODE_RST 7'h00
`define GESC_BYTE_RST 8'h00
`define GESC_SYNC_CNT_RST 8'h10
`define GESC_TH_MUL 8'hA3
`define GESC_TH_SHIFT 7
`define GESC_COEF_RST 8'h80
`define GESC_COEF_MAX 8'hFF
`define GESC_COEF_MIN 8'h00
`define GESC_SYNC_BYTE 8'h96
`define GESC_SYNC_CW 9'h136
`define GESC_AM_CW 9'h1E1
`define GESC_PRE_CW 9'h1FF
`define GESC_AM_WORDS 8'h02
`define GESC_SCR_SEED 10'h3FF
`define GESC_LAST_BIT 4'h8
`define GESC_MODE_IDLE 2'h0
`define GESC_MODE_WRITE 2'h1
`define GESC_MODE_READ 2'h2
`define GESC_MODE_SERVO 2'h3
`endif

// File: core/gesc_scram.v
`timescale 1ns/1ps
`default_nettype none
`include "gesc_regs.vh"
module gesc_scram #(parameter SW = 10, parameter TAP = 7) (
  input wire clk,
  input wire rst,
  input wire seed_load,
  input wire step,
  input wire enable,
  input wire [7:0] data_in,
  output wire [7:0] data_out
);
  reg [SW-1:0] lfsr_r;
  reg [SW-1:0] lfsr_nxt;
  reg [7:0] key;
  reg fb;
  integer k;

  // Additive key, eight shifts of x^10 + x^7 + 1 per byte
  always @* begin
    lfsr_nxt = lfsr_r;
    key = 8'h00;
    fb = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      fb = lfsr_nxt[SW-1] ^ lfsr_nxt[TAP-1];
      key[7-k] = fb;
      lfsr_nxt = {lfsr_nxt[SW-2:0], fb};
    end
  end

  assign data_out = enable ? (data_in ^ key) : data_in;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_r <= `GESC_SCR_SEED;
    end else if (seed_load) begin
      lfsr_r <= `GESC_SCR_SEED;
    end else if (step) begin
      lfsr_r <= lfsr_nxt;
    end
  end
endmodule
`default_nettype wire

// File: core/gesc_sync9.v
`timescale 1ns/1ps
`default_nettype none
`include "gesc_regs.vh"
module gesc_sync9 #(parameter W = 9, parameter [8:0] PAT = `GESC_SYNC_CW) (
  input wire clk,
  input wire rst,
  input wire bit_en,
  input wire bit_in,
  input wire hunt,
  output reg [W-1:0] word_r,
  output reg word_stb_r,
  output reg found_r
);
  reg [W-1:0] sh_r;
  reg [3:0] cnt_r;
  reg locked_r;
  wire [W-1:0] sh_nxt = {sh_r[W-2:0], bit_in};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= 9'h000;
      cnt_r <= 4'h0;
      locked_r <= 1'b0;
      word_r <= 9'h000;
      word_stb_r <= 1'b0;
      found_r <= 1'b0;
    end else begin
      word_stb_r <= 1'b0;
      found_r <= 1'b0;
      if (!bit_en) begin
        locked_r <= 1'b0;
        cnt_r <= 4'h0;
      end else begin
        sh_r <= sh_nxt;
        if (!locked_r) begin
          if (hunt && sh_nxt == PAT) begin
            locked_r <= 1'b1;
            found_r <= 1'b1;
            cnt_r <= 4'h0;
          end
        end else if (cnt_r == `GESC_LAST_BIT) begin
          cnt_r <= 4'h0;
          word_r <= sh_nxt;
          word_stb_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/gesc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "gesc_regs.vh"
module gesc_top #(parameter CW = 7, parameter BW = 8) (
  input wire CLK_SYS,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire SERVO_GATE,
  input wire READ_GATE,
  input wire WRITE_GATE,
  input wire [7:0] WR_BYTE_IN,
  output reg WR_BYTE_TAKE,
  output reg WRITE_DATA_OUT,
  output reg WRITE_DATA_OUT_N,
  input wire RD_BIT_IN,
  output reg [7:0] RD_BYTE_OUT,
  output reg RD_BYTE_STB,
  output reg SYNC_COUNT_REACHED,
  input wire EQ_TRAINING,
  input wire EQ_ERR_VALID,
  input wire EQ_ERR_POS,
  output reg [7:0] OUTER_TAP_COEF,
  output reg [CW-1:0] FC_CODE,
  output reg [CW-1:0] BOOST_CODE,
  output reg [CW-1:0] DAMP_CODE,
  output reg [7:0] TH_LEVEL,
  output reg TH_ADAPT_ACTIVE,
  output reg [2:0] TH_TIME_CONST,
  output reg PD_DECISION_DIR,
  output reg [BW-1:0] SYNTH_M,
  output reg [BW-1:0] SYNTH_N,
  output reg [BW-1:0] RATE_SETTING,
  output reg TEST_PIN_POS,
  output reg TEST_PIN_NEG,
  output reg [1:0] MODE
);
  localparam W_IDLE = 3'h0;
  localparam W_AM = 3'h1;
  localparam W_PRE = 3'h2;
  localparam W_SYNC = 3'h3;
  localparam W_DATA = 3'h4;

  function gesc_mapped;
    input [7:0] a;
    begin
      gesc_mapped = (a[1:0] == 2'h0) && (a <= `GESC_A_SYNCCNT);
    end
  endfunction

  function [1:0] gesc_mode;
    input [2:0] g;
    begin
      if (g[2]) begin
        gesc_mode = `GESC_MODE_SERVO;
      end else if (g[1]) begin
        gesc_mode = `GESC_MODE_READ;
      end else if (g[0]) begin
        gesc_mode = `GESC_MODE_WRITE;
      end else begin
        gesc_mode = `GESC_MODE_IDLE;
      end
    end
  endfunction

  // Nibble split around a forced one
  function [8:0] gesc_enc;
    input [7:0] b;
    begin
      gesc_enc = {b[7:4], 1'b1, b[3:0]};
    end
  endfunction

  function [7:0] gesc_dec;
    input [8:0] c;
    begin
      gesc_dec = {c[8:5], c[3:0]};
    end
  endfunction

  // Gate pins: three stages, change accepted when stages two and three agree
  wire [2:0] gate_pin = {SERVO_GATE, READ_GATE, WRITE_GATE};
  reg [2:0] g1_r;
  reg [2:0] g2_r;
  reg [2:0] g3_r;
  reg [2:0] gs_r;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gsync
      always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          g1_r[gi] <= 1'b0;
          g2_r[gi] <= 1'b0;
          g3_r[gi] <= 1'b0;
          gs_r[gi] <= 1'b0;
        end else begin
          g1_r[gi] <= gate_pin[gi];
          g2_r[gi] <= g1_r[gi];
          g3_r[gi] <= g2_r[gi];
          if (g2_r[gi] == g3_r[gi]) begin
            gs_r[gi] <= g3_r[gi];
          end
        end
      end
    end
  endgenerate

  wire [1:0] mode_nxt = gesc_mode(gs_r);
  wire m_write = (MODE == `GESC_MODE_WRITE);
  wire m_read = (MODE == `GESC_MODE_READ);
  wire m_servo = (MODE == `GESC_MODE_SERVO);
  wire m_idle = (MODE == `GESC_MODE_IDLE);

  // Register file
  reg ctrl_scr_r;
  reg [CW-1:0] dfc_r;
  reg [CW-1:0] dboost_r;
  reg [CW-1:0] sfc_code_r;
  reg [CW-1:0] sboost_r;
  reg [1:0] sloop_r;
  reg [CW-1:0] lth_r;
  reg [3:0] wplt_r;
  reg [CW-1:0] damp_r;
  reg [BW-1:0] m_pend_r;
  reg [BW-1:0] n_pend_r;
  reg test_syn_r;
  reg [7:0] sync_cnt_r;
  reg [2:0] wst_r;
  reg synced_r;
  reg [31:0] rd_mux;

  wire wr_acc = PSEL & PENABLE & PWRITE & PREADY & gesc_mapped(PADDR);

  always @* begin
    rd_mux = 32'h00000000;
    case (PADDR)
      `GESC_A_CTRL: rd_mux[`GESC_CTRL_SCR_BIT] = ctrl_scr_r;
      `GESC_A_DFC: rd_mux[CW-1:0] = dfc_r;
      `GESC_A_DBOOST: rd_mux[CW-1:0] = dboost_r;
      `GESC_A_SFC: rd_mux[CW-1:0] = sfc_code_r;
      `GESC_A_SBOOST: rd_mux[CW-1:0] = sboost_r;
      `GESC_A_SLOOP: rd_mux[1:0] = sloop_r;
      `GESC_A_THRESH: rd_mux[CW-1:0] = lth_r;
      `GESC_A_WPLT: rd_mux[3:0] = wplt_r;
      `GESC_A_DAMP: rd_mux[CW-1:0] = damp_r;
      `GESC_A_SYN_M: rd_mux[BW-1:0] = m_pend_r;
      `GESC_A_SYN_N: rd_mux[BW-1:0] = n_pend_r;
      `GESC_A_RATE: rd_mux[BW-1:0] = RATE_SETTING;
      `GESC_A_TEST: rd_mux[`GESC_TEST_SYN_BIT] = test_syn_r;
      `GESC_A_STATUS: rd_mux[15:0] = {OUTER_TAP_COEF, wst_r, synced_r, SYNC_COUNT_REACHED, 1'b0, MODE};
      `GESC_A_SYNCCNT: rd_mux[7:0] = sync_cnt_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
      ctrl_scr_r <= 1'b0;
      dfc_r <= `GESC_CODE_RST;
      dboost_r <= `GESC_CODE_RST;
      sfc_code_r <= `GESC_CODE_RST;
      sboost_r <= `GESC_CODE_RST;
      sloop_r <= 2'h0;
      lth_r <= `GESC_CODE_RST;
      wplt_r <= 4'h0;
      damp_r <= `GESC_CODE_RST;
      m_pend_r <= `GESC_BYTE_RST;
      n_pend_r <= `GESC_BYTE_RST;
      SYNTH_M <= `GESC_BYTE_RST;
      SYNTH_N <= `GESC_BYTE_RST;
      RATE_SETTING <= `GESC_BYTE_RST;
      test_syn_r <= 1'b0;
      sync_cnt_r <= `GESC_SYNC_CNT_RST;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      if (PSEL & ~PENABLE) begin
        PRDATA <= rd_mux;
        PSLVERR <= ~gesc_mapped(PADDR);
      end
      if (wr_acc) begin
        case (PADDR)
          `GESC_A_CTRL: ctrl_scr_r <= PWDATA[`GESC_CTRL_SCR_BIT];
          `GESC_A_DFC: dfc_r <= PWDATA[CW-1:0];
          `GESC_A_DBOOST: dboost_r <= PWDATA[CW-1:0];
          `GESC_A_SFC: sfc_code_r <= PWDATA[CW-1:0];
          `GESC_A_SBOOST: sboost_r <= PWDATA[CW-1:0];
          `GESC_A_SLOOP: sloop_r <= PWDATA[1:0];
          `GESC_A_THRESH: lth_r <= PWDATA[CW-1:0];
          `GESC_A_WPLT: wplt_r <= PWDATA[3:0];
          `GESC_A_DAMP: damp_r <= PWDATA[CW-1:0];
          `GESC_A_SYN_M: m_pend_r <= PWDATA[BW-1:0];
          `GESC_A_SYN_N: n_pend_r <= PWDATA[BW-1:0];
          `GESC_A_RATE: begin
            RATE_SETTING <= PWDATA[BW-1:0];
            SYNTH_M <= m_pend_r;
            SYNTH_N <= n_pend_r;
          end
          `GESC_A_TEST: test_syn_r <= PWDATA[`GESC_TEST_SYN_BIT];
          `GESC_A_SYNCCNT: sync_cnt_r <= PWDATA[7:0];
          default: ctrl_scr_r <= ctrl_scr_r;
        endcase
      end
    end
  end

  // Shared scrambler, write and read never overlap
  wire [8:0] rd_word;
  wire rd_word_stb;
  wire rd_found;
  wire [7:0] scr_out;
  reg [3:0] bit_cnt_r;
  reg [7:0] word_cnt_r;
  reg [8:0] sh_r;
  wire last_bit = (bit_cnt_r == `GESC_LAST_BIT);
  wire wr_seed = m_write && last_bit && (wst_r == W_PRE) && (word_cnt_r == sync_cnt_r - 8'h01);
  wire wr_step = m_write && last_bit && ((wst_r == W_SYNC) || (wst_r == W_DATA));
  wire rd_desc = m_read && synced_r && rd_word_stb;

  gesc_scram u_scram (
    .clk(CLK_SYS),
    .rst(RST),
    .seed_load(wr_seed | (m_read & rd_found)),
    .step(wr_step | rd_desc),
    .enable(ctrl_scr_r & (wr_step | rd_desc)),
    .data_in(m_write ? WR_BYTE_IN : gesc_dec(rd_word)),
    .data_out(scr_out)
  );

  gesc_sync9 u_sync9 (
    .clk(CLK_SYS),
    .rst(RST),
    .bit_en(m_read),
    .bit_in(RD_BIT_IN),
    .hunt(SYNC_COUNT_REACHED),
    .word_r(rd_word),
    .word_stb_r(rd_word_stb),
    .found_r(rd_found)
  );

  // Write framer, runs on the system clock CLK_SYS
  reg [1:0] pc_r;
  wire pbit = sh_r[8] ^ pc_r[1];
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wst_r <= W_IDLE;
      bit_cnt_r <= 4'h0;
      word_cnt_r <= 8'h00;
      sh_r <= 9'h000;
      pc_r <= 2'h0;
      WRITE_DATA_OUT <= 1'b0;
      WRITE_DATA_OUT_N <= 1'b1;
      WR_BYTE_TAKE <= 1'b0;
    end else begin
      WR_BYTE_TAKE <= 1'b0;
      if (!m_write) begin
        wst_r <= W_IDLE;
        bit_cnt_r <= 4'h0;
        pc_r <= 2'h0;
        WRITE_DATA_OUT <= 1'b0;
        WRITE_DATA_OUT_N <= 1'b1;
      end else if (wst_r == W_IDLE) begin
        wst_r <= W_AM;
        sh_r <= `GESC_AM_CW;
        word_cnt_r <= 8'h00;
        bit_cnt_r <= 4'h0;
      end else begin
        pc_r <= {pc_r[0], pbit};
        if (pbit) begin
          WRITE_DATA_OUT <= ~WRITE_DATA_OUT;
          WRITE_DATA_OUT_N <= WRITE_DATA_OUT;
        end
        if (!last_bit) begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          sh_r <= {sh_r[7:0], 1'b0};
        end else begin
          bit_cnt_r <= 4'h0;
          word_cnt_r <= word_cnt_r + 8'h01;
          case (wst_r)
            W_AM: begin
              if (word_cnt_r == `GESC_AM_WORDS - 8'h01) begin
                wst_r <= W_PRE;
                word_cnt_r <= 8'h00;
                sh_r <= `GESC_PRE_CW;
              end else begin
                sh_r <= `GESC_AM_CW;
              end
            end
            W_PRE: begin
              if (wr_seed) begin
                wst_r <= W_SYNC;
                sh_r <= gesc_enc(`GESC_SYNC_BYTE);
              end else begin
                sh_r <= `GESC_PRE_CW;
              end
            end
            W_SYNC, W_DATA: begin
              wst_r <= W_DATA;
              sh_r <= gesc_enc(scr_out);
              WR_BYTE_TAKE <= 1'b1;
            end
            default: wst_r <= W_IDLE;
          endcase
        end
      end
    end
  end

  // Read side: preamble count, sync byte, descramble
  reg [7:0] ones_cnt_r;
  wire user_ph = m_read & synced_r;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ones_cnt_r <= 8'h00;
      SYNC_COUNT_REACHED <= 1'b0;
      synced_r <= 1'b0;
      RD_BYTE_OUT <= 8'h00;
      RD_BYTE_STB <= 1'b0;
    end else begin
      RD_BYTE_STB <= 1'b0;
      if (!m_read) begin
        ones_cnt_r <= 8'h00;
        SYNC_COUNT_REACHED <= 1'b0;
        synced_r <= 1'b0;
        RD_BYTE_OUT <= 8'h00;
      end else if (!SYNC_COUNT_REACHED) begin
        if (!RD_BIT_IN) begin
          ones_cnt_r <= 8'h00;
        end else if (ones_cnt_r + 8'h01 >= sync_cnt_r) begin
          SYNC_COUNT_REACHED <= 1'b1;
        end else begin
          ones_cnt_r <= ones_cnt_r + 8'h01;
        end
      end else if (!synced_r) begin
        RD_BYTE_STB <= 1'b1;
        if (rd_found) begin
          synced_r <= 1'b1;
          RD_BYTE_OUT <= `GESC_SYNC_BYTE;
        end else begin
          RD_BYTE_OUT <= 8'h00;
          RD_BYTE_STB <= 1'b0;
        end
      end else if (rd_word_stb) begin
        RD_BYTE_OUT <= scr_out;
        RD_BYTE_STB <= 1'b1;
      end
    end
  end

  // Analog loop controls
  wire [15:0] th_prod = {9'h000, lth_r} * {8'h00, `GESC_TH_MUL};
  wire adapt_ok = sloop_r[`GESC_SL_ON_BIT] && m_read && EQ_ERR_VALID &&
                  (EQ_TRAINING || (sloop_r[`GESC_SL_USER_BIT] && user_ph));
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MODE <= `GESC_MODE_IDLE;
      FC_CODE <= `GESC_CODE_RST;
      BOOST_CODE <= `GESC_CODE_RST;
      DAMP_CODE <= `GESC_CODE_RST;
      TH_LEVEL <= 8'h00;
      TH_ADAPT_ACTIVE <= 1'b0;
      TH_TIME_CONST <= 3'h0;
      PD_DECISION_DIR <= 1'b0;
      OUTER_TAP_COEF <= `GESC_COEF_RST;
      TEST_PIN_POS <= 1'b0;
      TEST_PIN_NEG <= 1'b0;
    end else begin
      MODE <= mode_nxt;
      FC_CODE <= m_servo ? sfc_code_r : dfc_r;
      BOOST_CODE <= m_servo ? sboost_r : dboost_r;
      DAMP_CODE <= damp_r;
      PD_DECISION_DIR <= m_read;
      TH_TIME_CONST <= wplt_r[`GESC_WL_TC_HI:`GESC_WL_TC_LO];
      TH_ADAPT_ACTIVE <= wplt_r[`GESC_WL_ADAPT_BIT] & SYNC_COUNT_REACHED;
      if (SYNC_COUNT_REACHED) begin
        TH_LEVEL <= {1'b0, lth_r};
      end else begin
        TH_LEVEL <= th_prod[`GESC_TH_SHIFT+7:`GESC_TH_SHIFT];
      end
      // Positive zero-sample residue means too much outer tap
      if (adapt_ok) begin
        if (EQ_ERR_POS && OUTER_TAP_COEF != `GESC_COEF_MIN) begin
          OUTER_TAP_COEF <= OUTER_TAP_COEF - 8'h01;
        end else if (!EQ_ERR_POS && OUTER_TAP_COEF != `GESC_COEF_MAX) begin
          OUTER_TAP_COEF <= OUTER_TAP_COEF + 8'h01;
        end
      end
      if (test_syn_r && (m_write || m_idle)) begin
        TEST_PIN_POS <= ~TEST_PIN_POS;
        TEST_PIN_NEG <= TEST_PIN_POS;
      end else begin
        TEST_PIN_POS <= 1'b0;
        TEST_PIN_NEG <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: core/gesc_top_end.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: testbench/gesc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gesc_checker #(parameter BW = 8) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic SERVO_GATE,
  input wire logic READ_GATE,
  input wire logic WR_BYTE_TAKE,
  input wire logic WRITE_DATA_OUT,
  input wire logic [7:0] RD_BYTE_OUT,
  input wire logic RD_BYTE_STB,
  input wire logic EQ_ERR_VALID,
  input wire logic [7:0] OUTER_TAP_COEF,
  input wire logic PD_DECISION_DIR,
  input wire logic [BW-1:0] SYNTH_M,
  input wire logic [BW-1:0] RATE_SETTING,
  input wire logic TEST_PIN_POS,
  input wire logic [1:0] MODE
);
  logic seen_r;
  wire [BW-1:0] wlow = PWDATA[BW-1:0];
  wire rate_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h2C;
  wire rd2 = MODE == 2'h2;
  // First strobe of a read sector seen
  always_ff @(posedge CLK_SYS or posedge RST)
    if (RST)
      seen_r <= 1'h0;
    else
      seen_r <= rd2 && (seen_r || RD_BYTE_STB);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_rate_load: assert property (rate_wr |=> RATE_SETTING == $past(wlow))
    else $error("rate not loaded");
  a_synth_hold: assert property ($changed(SYNTH_M) |-> $past(rate_wr))
    else $error("multiplier changed without commit");
  a_coef_cause: assert property ($changed(OUTER_TAP_COEF) |-> $past(EQ_ERR_VALID) || $past(EQ_ERR_VALID, 2))
    else $error("coefficient moved without error sample");
  a_servo_wins: assert property (SERVO_GATE [*7] |-> MODE == 2'h3)
    else $error("servo gate not obeyed");
  a_read_wins: assert property ((READ_GATE && !SERVO_GATE) [*7] |-> rd2)
    else $error("read gate not obeyed");
  a_dd_read: assert property (rd2 && $past(MODE) == 2'h2 |-> PD_DECISION_DIR)
    else $error("detector choice wrong in read");
  a_pf_other: assert property (!rd2 && $past(MODE) != 2'h2 |-> !PD_DECISION_DIR)
    else $error("detector choice wrong outside read");
  a_test_quiet: assert property (rd2 && $past(MODE) == 2'h2 && $past(MODE, 2) == 2'h2 |-> $stable(TEST_PIN_POS))
    else $error("test pin active in read");
  a_wd_idle: assert property (MODE != 2'h1 && $past(MODE) != 2'h1 |-> !WRITE_DATA_OUT)
    else $error("write toggle not reset");
  a_take_gap: assert property (WR_BYTE_TAKE |=> !WR_BYTE_TAKE [*8])
    else $error("byte taken too soon");
  a_sync_first: assert property (RD_BYTE_STB && !seen_r && rd2 |-> RD_BYTE_OUT == 8'h96)
    else $error("first byte not sync byte");
endmodule
bind gesc_top gesc_checker #(.BW(BW)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .SERVO_GATE(SERVO_GATE),
  .READ_GATE(READ_GATE), .WR_BYTE_TAKE(WR_BYTE_TAKE), .WRITE_DATA_OUT(WRITE_DATA_OUT),
  .RD_BYTE_OUT(RD_BYTE_OUT), .RD_BYTE_STB(RD_BYTE_STB), .EQ_ERR_VALID(EQ_ERR_VALID),
  .OUTER_TAP_COEF(OUTER_TAP_COEF), .PD_DECISION_DIR(PD_DECISION_DIR), .SYNTH_M(SYNTH_M),
  .RATE_SETTING(RATE_SETTING), .TEST_PIN_POS(TEST_PIN_POS), .MODE(MODE));
`default_nettype wire

// File: testbench/gesc_partner.sv
`timescale 1ns/1ps
`default_nettype none
`include "gesc_regs.vh"
module gesc_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_go,
  input wire logic take,
  input wire logic rd_go,
  output logic [7:0] wr_byte,
  output logic rd_bit
);
  logic [8:0] sh_r;
  logic [4:0] ones_r;
  logic [3:0] bit_r;
  logic [7:0] k_r;
  logic alt_r;
  wire [7:0] db = 8'hC3 + k_r;
  // Byte source steps only once the encoder took a byte
  always @(posedge clk or posedge rst)
    if (rst || !wr_go)
      wr_byte <= 8'h40;
    else if (take)
      wr_byte <= wr_byte + 8'h01;
  // Idle line pattern changes every cycle
  always @(posedge clk or posedge rst)
    if (rst)
      alt_r <= 1'h0;
    else
      alt_r <= !alt_r;
  // Preamble ones, sync word, then coded bytes MSB first
  always @(posedge clk or posedge rst)
    if (rst || !rd_go) begin
      ones_r <= 5'h00;
      bit_r <= 4'h0;
      k_r <= 8'h00;
      sh_r <= `GESC_SYNC_CW;
    end else if (ones_r != 5'h18)
      ones_r <= ones_r + 5'h01;
    else if (bit_r == 4'h8) begin
      bit_r <= 4'h0;
      sh_r <= {db[7:4], 1'h1, db[3:0]};
      k_r <= k_r + 8'h01;
    end else begin
      bit_r <= bit_r + 4'h1;
      sh_r <= {sh_r[7:0], 1'h0};
    end
  assign rd_bit = !rd_go ? alt_r : (ones_r != 5'h18) || sh_r[8];
endmodule
`default_nettype wire

// File: testbench/tb_gcr_endec_scrambler_sync_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gcr_endec_scrambler_sync_control;
  logic clk, rst, psel, pen, pwr, pready, perr, sg, rg, wg, take, wd, wdn, rbit, rstb, sync_count_reached;
  logic eqt, eqv, eqp, tha, pd, tp, tpn, er, up, w1, p1, p2, wf;
  logic [7:0] paddr, wbyte, rbyte, coef, th, sm, sn, rate, b1, b2, s1, s2, c0, wb;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] fc, bst, dmp;
  logic [2:0] tc;
  logic [1:0] mode;
  logic [26:0] ws;
  integer fail_count = 0, comparisons = 0, i, n, wn;
  // Address, write value, read value, error flag
  logic [24:0] rows [0:11] = '{{8'h04, 8'h15, 8'h15, 1'h0}, {8'h08, 8'h2A, 8'h2A, 1'h0},
    {8'h0C, 8'h33, 8'h33, 1'h0}, {8'h10, 8'h44, 8'h44, 1'h0}, {8'h20, 8'h5B, 8'h5B, 1'h0},
    {8'h24, 8'h12, 8'h12, 1'h0}, {8'h28, 8'h07, 8'h07, 1'h0}, {8'h18, 8'h40, 8'h40, 1'h0},
    {8'h1C, 8'h0A, 8'h0A, 1'h0}, {8'h30, 8'h01, 8'h01, 1'h0}, {8'h3C, 8'hAA, 8'h00, 1'h1},
    {8'h06, 8'h11, 8'h00, 1'h1}};
  gesc_top dut (.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr), .SERVO_GATE(sg), .READ_GATE(rg),
    .WRITE_GATE(wg), .WR_BYTE_IN(wbyte), .WR_BYTE_TAKE(take), .WRITE_DATA_OUT(wd), .WRITE_DATA_OUT_N(wdn),
    .RD_BIT_IN(rbit), .RD_BYTE_OUT(rbyte), .RD_BYTE_STB(rstb), .SYNC_COUNT_REACHED(sync_count_reached), .EQ_TRAINING(eqt),
    .EQ_ERR_VALID(eqv), .EQ_ERR_POS(eqp), .OUTER_TAP_COEF(coef), .FC_CODE(fc), .BOOST_CODE(bst),
    .DAMP_CODE(dmp), .TH_LEVEL(th), .TH_ADAPT_ACTIVE(tha), .TH_TIME_CONST(tc), .PD_DECISION_DIR(pd),
    .SYNTH_M(sm), .SYNTH_N(sn), .RATE_SETTING(rate), .TEST_PIN_POS(tp), .TEST_PIN_NEG(tpn), .MODE(mode));
  gesc_partner u_far (.clk(clk), .rst(rst), .wr_go(mode == 2'h1), .take(take), .rd_go(mode == 2'h2),
    .wr_byte(wbyte), .rd_bit(rbit));
  initial begin
    clk = 1'h0;
    forever #25 clk = !clk;
  end
  task automatic chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task complete_run;
    begin
      if (fail_count == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'h1;
      paddr <= a;
      pwr <= w;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do @(posedge clk); while (!pready);
      rd = prdata;
      er = perr;
      psel <= 1'h0;
      pen <= 1'h0;
    end
  endtask
  task gt(input s, input r, input w, input [1:0] m);
    begin
      sg <= s;
      rg <= r;
      wg <= w;
      repeat (7) @(posedge clk);
      chk(mode, m);
    end
  endtask
  task nb;
    begin
      n = 0;
      do begin
        @(posedge clk);
        n = n + 1;
      end while (!rstb && n < 40);
      chk(rstb, 1'h1);
    end
  endtask
  task eqc(input t, input p, input ch);
    begin
      eqt <= t;
      eqp <= p;
      eqv <= 1'h1;
      c0 = coef;
      repeat (4) @(posedge clk);
      eqv <= 1'h0;
      repeat (3) @(posedge clk);
      up = coef > c0;
      chk(coef !== c0, ch);
    end
  endtask
  task rdsec(input adp);
    begin
      gt(1'h0, 1'h1, 1'h0, 2'h2);
      chk(pd, 1'h1);
      chk(rbyte, 8'h00);
      chk(th, 8'h51);
      chk(tha, 1'h0);
      nb;
      chk(rbyte, 8'h96);
      chk(sync_count_reached, 1'h1);
      chk(tha, adp);
      nb;
      b1 = rbyte;
      nb;
      b2 = rbyte;
    end
  endtask
  // Undo toggle and precoder to recover code bits
  always @(posedge clk) begin
    if (mode !== 2'h1) begin
      w1 = 1'h0;
      p1 = 1'h0;
      p2 = 1'h0;
      ws = 27'h0;
      wf = 1'h0;
      wn = 0;
      wb = 8'h40;
    end else begin
      chk(wdn, !wd);
      ws = {ws[25:0], wd ^ w1 ^ p2};
      p2 = p1;
      p1 = wd ^ w1;
      w1 = wd;
      wn = wn + 1;
      if (!wf && ws[8:0] == 9'h136) begin
        wf = 1'h1;
        wn = 0;
        chk(ws[17:9], 9'h1FF);
      end else if (wf && wn == 9) begin
        wn = 0;
        chk(ws[8:0], {wb[7:4], 1'h1, wb[3:0]});
        wb = wb + 8'h01;
      end
    end
  end
  initial begin
    #200000;
    fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    {rst, psel, pen, pwr, sg, rg, wg, eqt, eqv, eqp} = 10'h200;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    chk({coef, wdn}, {8'h80, 1'h1});
    apb(8'h38, 1'h0, 32'h0);
    chk(rd, 32'h10);
    for (i = 0; i < 12; i = i + 1) begin
      apb(rows[i][24:17], 1'h1, {24'h0, rows[i][16:9]});
      apb(rows[i][24:17], 1'h0, 32'h0);
      chk(rd, {24'h0, rows[i][8:1]});
      chk(er, rows[i][0]);
    end
    chk({fc, bst, dmp, tc, sm}, {7'h15, 7'h2A, 7'h5B, 3'h5, 8'h00});
    chk(tc, 3'h5);
    apb(8'h2C, 1'h1, 32'h09);
    @(posedge clk);
    chk({sm, sn, rate}, 24'h120709);
    b1 = tp;
    @(posedge clk);
    chk(tp !== b1, 1'h1);
    chk(tpn, b1[0]);
    gt(1'h1, 1'h1, 1'h1, 2'h3);
    chk({fc, bst, pd}, {7'h33, 7'h44, 1'h0});
    gt(1'h0, 1'h1, 1'h1, 2'h2);
    gt(1'h0, 1'h0, 1'h1, 2'h1);
    repeat (260) @(posedge clk);
    chk(wf && wb > 8'h43, 1'h1);
    gt(1'h0, 1'h0, 1'h0, 2'h0);
    chk({fc, bst}, {7'h15, 7'h2A});
    rdsec(1'h0);
    chk({th, b1, b2}, 24'h40C3C4);
    eqc(1'h1, 1'h1, 1'h0);
    apb(8'h14, 1'h1, 32'h1);
    eqc(1'h1, 1'h1, 1'h1);
    s1 = {7'h00, up};
    eqc(1'h1, 1'h0, 1'h1);
    chk(up, !s1[0]);
    eqc(1'h0, 1'h1, 1'h0);
    apb(8'h14, 1'h1, 32'h3);
    eqc(1'h0, 1'h1, 1'h1);
    gt(1'h0, 1'h0, 1'h0, 2'h0);
    chk(pd, 1'h0);
    apb(8'h1C, 1'h1, 32'h0B);
    apb(8'h00, 1'h1, 32'h04);
    rdsec(1'h1);
    s1 = b1;
    s2 = b2;
    chk({b1, b2} !== 16'hC3C4, 1'h1);
    chk({b1, b2}, 16'hC207);
    gt(1'h0, 1'h0, 1'h0, 2'h0);
    rdsec(1'h1);
    chk({b1, b2}, {s1, s2});
    gt(1'h0, 1'h0, 1'h0, 2'h0);
    complete_run;
  end
endmodule
`default_nettype wire
